// ==== common/hut_pkg.sv ====
// Constants and types shared by the host-link UART transport.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package hut_pkg;

  // Clock and bit timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_DEFAULT_BPS = 115_200;
  localparam int unsigned BAUD_MAX_BPS = 4_000_000;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT_BPS);
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_MAX_BPS);
  localparam logic [19:0] IDLE_BITS = 20'h0000a;

  // Frame shape
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] LAST_BIT_PLAIN = 4'h9;
  localparam logic [3:0] LAST_BIT_PARITY = 4'ha;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Receive buffer and flow control threshold (a quarter of the depth kept as headroom)
  localparam int unsigned FIFO_DEPTH = 64;
  localparam int unsigned PTR_W = 6;
  localparam logic [6:0] FIFO_FULL = 7'h40;
  localparam logic [6:0] RTS_LEVEL = 7'h30;

  // Register byte offsets
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_BAUD = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0c;

  // Sticky status flags, write one to clear
  localparam int unsigned FLAG_W = 7;
  localparam int unsigned FL_BREAK = 0;
  localparam int unsigned FL_IDLE = 1;
  localparam int unsigned FL_FRAMING = 2;
  localparam int unsigned FL_OVERFLOW = 3;
  localparam int unsigned FL_PARITY = 4;
  localparam int unsigned FL_RX_UNDER = 5;
  localparam int unsigned FL_TX_UNDER = 6;
  // Live status bits
  localparam int unsigned ST_RX_NONEMPTY = 8;
  localparam int unsigned ST_TX_HOLD = 9;
  localparam int unsigned ST_TX_BUSY = 10;
  localparam int unsigned ST_RTS = 11;
  localparam int unsigned ST_CTS = 12;
  localparam int unsigned ST_BAUD_PEND = 13;
  localparam int unsigned ST_COUNT_LSB = 16;
  // Control bits
  localparam int unsigned CT_PAR_EN = 0;
  localparam int unsigned CT_PAR_ODD = 1;
  localparam int unsigned CT_TX_BURST = 2;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND} hut_tx_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} hut_rx_type;

endpackage : hut_pkg

// ==== verilog/hut_uart.sv ====
// HCI UART transport: four-wire UART with hardware flow control and
// software register access over Avalon-MM with waitrequest.
// Assumes pins are asynchronous to clk_i and the bus master holds requests.
`timescale 1ns/100ps
`default_nettype none

module hut_uart
  import hut_pkg::*;
(
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic [4:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Write byte lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data, registered
  output logic avs_waitrequest_o, // Stall, combinational
  input wire logic uart_rxd_i, // Serial data from host
  output logic uart_txd_o, // Serial data to host, registered
  input wire logic transport_clear_to_send_in_i, // High asks us to stop sending
  output logic uart_rts_o // High asks host to stop, registered
);

  typedef struct packed {
    logic rxd_s1;
    logic rxd_s2;
    logic cts_s1;
    logic cts_s2;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] div;
    logic [15:0] div_pend;
    logic div_arm;
    logic par_en;
    logic par_odd;
    logic tx_burst;
    hut_tx_type tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [10:0] tx_sh;
    logic txd;
    logic [7:0] tx_hold;
    logic tx_hold_v;
    hut_rx_type rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic [19:0] idle_cnt;
    logic idle_arm;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [6:0] count;
    logic [FLAG_W-1:0] flags;
    logic rts;
  } hut_state_type;

  hut_state_type s_r;
  hut_state_type s_nxt;

  // Parity of a data byte, odd or even sense
  function automatic logic hut_parity(input logic [7:0] d, input logic odd);
    hut_parity = (^d) ^ odd;
  endfunction : hut_parity

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] hut_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    hut_merge = (old & ~m) | (wd & m);
  endfunction : hut_merge

  // Bus handshake: data writes wait while the holding register is full
  logic req;
  logic wr_blocked;
  assign req = avs_read_i | avs_write_i;
  assign wr_blocked = avs_write_i && (avs_address_i == OFS_DATA) && s_r.tx_hold_v;
  assign avs_waitrequest_o = req & ~s_r.ack;

  // Next-state logic for the whole transport
  always_comb begin
    logic [FLAG_W-1:0] fset;
    logic [FLAG_W-1:0] fclr;
    logic push;
    logic pop;
    logic done_bus;
    logic [31:0] merged;
    logic [31:0] stat;
    logic [10:0] frame;
    fset = '0;
    fclr = '0;
    push = 1'b0;
    pop = 1'b0;
    done_bus = req & s_r.ack;
    merged = '0;
    frame = '0;
    stat = '0;
    s_nxt = s_r;

    // Two-stage synchronisers on the asynchronous pins
    s_nxt.rxd_s1 = uart_rxd_i;
    s_nxt.rxd_s2 = s_r.rxd_s1;
    s_nxt.cts_s1 = transport_clear_to_send_in_i;
    s_nxt.cts_s2 = s_r.cts_s1;

    // Status word as software sees it
    stat[FLAG_W-1:0] = s_r.flags;
    stat[ST_RX_NONEMPTY] = (s_r.count != '0);
    stat[ST_TX_HOLD] = s_r.tx_hold_v;
    stat[ST_TX_BUSY] = (s_r.tx_st == TX_SEND);
    stat[ST_RTS] = s_r.rts;
    stat[ST_CTS] = s_r.cts_s2;
    stat[ST_BAUD_PEND] = s_r.div_arm;
    stat[ST_COUNT_LSB +: 7] = s_r.count;

    // Acknowledge one cycle after the request is seen; read data is captured then
    s_nxt.ack = req & ~s_r.ack & ~wr_blocked;
    if (req && !s_r.ack && avs_read_i) begin
      unique case (avs_address_i)
        OFS_DATA: s_nxt.rdata = (s_r.count != '0) ? {24'h000000, s_r.mem[s_r.rd_ptr]} : '0;
        OFS_STATUS: s_nxt.rdata = stat;
        OFS_BAUD: s_nxt.rdata = {16'h0000, s_r.div};
        OFS_CTRL: s_nxt.rdata = {29'h0, s_r.tx_burst, s_r.par_odd, s_r.par_en};
        default: s_nxt.rdata = '0; // Unmapped reads return zero
      endcase
    end

    // Side effects take place on the edge that completes the access
    if (done_bus && avs_read_i && avs_address_i == OFS_DATA) begin
      if (s_r.count != '0) begin
        pop = 1'b1;
      end else begin
        fset[FL_RX_UNDER] = 1'b1;
      end
    end
    if (done_bus && avs_write_i) begin
      unique case (avs_address_i)
        OFS_DATA: begin
          if (avs_byteenable_i[0]) begin
            s_nxt.tx_hold = avs_writedata_i[7:0];
            s_nxt.tx_hold_v = 1'b1;
          end
        end
        OFS_STATUS: begin
          merged = hut_merge('0, avs_writedata_i, avs_byteenable_i);
          fclr = merged[FLAG_W-1:0];
        end
        OFS_BAUD: begin
          // Rate from the vendor_specific command; held until the reply has gone out
          merged = hut_merge({16'h0000, s_r.div_pend}, avs_writedata_i, avs_byteenable_i);
          s_nxt.div_pend = (merged[15:0] < DIV_MIN) ? DIV_MIN : merged[15:0];
          s_nxt.div_arm = 1'b1;
        end
        OFS_CTRL: begin
          merged = hut_merge({29'h0, s_r.tx_burst, s_r.par_odd, s_r.par_en},
                             avs_writedata_i, avs_byteenable_i);
          s_nxt.par_en = merged[CT_PAR_EN];
          s_nxt.par_odd = merged[CT_PAR_ODD];
          s_nxt.tx_burst = merged[CT_TX_BURST];
        end
        default: ; // Unmapped writes are dropped
      endcase
    end

    // Transmitter: a byte starts only on a byte boundary with clear-to-send low
    unique case (s_r.tx_st)
      TX_IDLE: begin
        s_nxt.txd = 1'b1;
        if (s_r.tx_hold_v && !s_r.cts_s2) begin
          frame = {1'b1, s_r.par_en ? hut_parity(s_r.tx_hold, s_r.par_odd) : 1'b1,
                   s_r.tx_hold, 1'b0};
          s_nxt.txd = frame[0];
          s_nxt.tx_sh = {1'b1, frame[10:1]};
          s_nxt.tx_bit = '0;
          s_nxt.tx_cnt = s_r.div - 16'h0001;
          s_nxt.tx_hold_v = 1'b0;
          s_nxt.tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        // Clear-to-send is not looked at here, so a started byte always completes
        if (s_r.tx_cnt != '0) begin
          s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
        end else if (s_r.tx_bit == (s_r.par_en ? LAST_BIT_PARITY : LAST_BIT_PLAIN)) begin
          s_nxt.txd = 1'b1;
          s_nxt.tx_st = TX_IDLE;
          if (s_r.tx_burst && !s_r.tx_hold_v) begin
            fset[FL_TX_UNDER] = 1'b1;
          end
          // Switch rate only at the end of a byte, and only when the holding register is empty
          if (s_r.div_arm && !s_r.tx_hold_v) begin
            s_nxt.div = s_r.div_pend;
            s_nxt.div_arm = 1'b0;
          end
        end else begin
          s_nxt.txd = s_r.tx_sh[0];
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
          s_nxt.tx_bit = s_r.tx_bit + 4'h1;
          s_nxt.tx_cnt = s_r.div - 16'h0001;
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    // Receiver: start edge, then mid-bit sampling timed from that edge alone
    unique case (s_r.rx_st)
      RX_IDLE: begin
        if (!s_r.rxd_s2) begin
          s_nxt.rx_st = RX_START;
          s_nxt.rx_cnt = s_r.div >> 1;
        end
      end
      RX_START: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else if (!s_r.rxd_s2) begin
          s_nxt.rx_st = RX_DATA;
          s_nxt.rx_bit = '0;
          s_nxt.rx_perr = 1'b0;
          s_nxt.rx_cnt = s_r.div - 16'h0001;
        end else begin
          s_nxt.rx_st = RX_IDLE; // Glitch shorter than half a bit
        end
      end
      RX_DATA: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else begin
          s_nxt.rx_sh = {s_r.rxd_s2, s_r.rx_sh[DATA_BITS-1:1]};
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          if (s_r.rx_bit == LAST_DATA_BIT) begin
            s_nxt.rx_st = s_r.par_en ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else begin
          s_nxt.rx_perr = (s_r.rxd_s2 != hut_parity(s_r.rx_sh, s_r.par_odd));
          s_nxt.rx_cnt = s_r.div - 16'h0001;
          s_nxt.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
        end else if (!s_r.rxd_s2) begin
          // Bad stop bit: the byte is dropped; an all-zero frame with no parity error is a break
          fset[FL_FRAMING] = 1'b1;
          fset[FL_BREAK] = (s_r.rx_sh == '0) && !s_r.rx_perr;
          s_nxt.rx_st = RX_BRK;
        end else begin
          fset[FL_PARITY] = s_r.rx_perr;
          s_nxt.idle_arm = 1'b1;
          s_nxt.rx_st = RX_IDLE;
          if (s_r.count == FIFO_FULL) begin
            fset[FL_OVERFLOW] = 1'b1;
          end else begin
            push = 1'b1;
          end
        end
      end
      RX_BRK: begin
        // Wait for the line to return high before hunting for a start bit
        if (s_r.rxd_s2) begin
          s_nxt.rx_st = RX_IDLE;
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase

    // Idle line: ten bit times of mark after a received byte
    if (s_r.rx_st == RX_IDLE && s_r.rxd_s2 && s_r.idle_arm) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 20'h00001;
      if (s_r.idle_cnt == 20'({4'h0, s_r.div} * IDLE_BITS)) begin
        fset[FL_IDLE] = 1'b1;
        s_nxt.idle_arm = 1'b0;
        s_nxt.idle_cnt = '0;
      end
    end else begin
      s_nxt.idle_cnt = '0;
    end

    // Receive buffer: 64 entries, so 16 bytes of headroom above the threshold
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = s_r.rx_sh;
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    s_nxt.count = s_r.count + {6'h00, push} - {6'h00, pop};

    // Request-to-send follows the fill level on every byte
    s_nxt.rts = (s_nxt.count >= RTS_LEVEL);

    // A hardware event in the clearing cycle survives the clear
    s_nxt.flags = (s_r.flags & ~fclr) | fset;
  end

  // State register; reset gives the default rate and frame format
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.rxd_s1 <= 1'b1;
      s_r.rxd_s2 <= 1'b1;
      s_r.div <= DIV_DEFAULT;
      s_r.div_pend <= DIV_DEFAULT;
      s_r.txd <= 1'b1;
      s_r.tx_sh <= '1;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from state flip-flops
  assign avs_readdata_o = s_r.rdata;
  assign uart_txd_o = s_r.txd;
  assign uart_rts_o = s_r.rts;

endmodule : hut_uart
`default_nettype wire

// ==== test/hut_uart_monitor.sv ====
// Port-level assertions for the host-link UART transport.
// Assumes a bus master that holds each request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module hut_uart_monitor
  import hut_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [4:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Write lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic uart_rxd_i, // Serial in
  input wire logic uart_txd_o, // Serial out
  input wire logic transport_clear_to_send_in_i, // Stop request in
  input wire logic uart_rts_o // Stop request out
);
  typedef struct packed {
    logic [19:0] tx_run;
    logic [19:0] cts_run;
    logic [15:0] div_hi;
  } hut_mon_type;
  hut_mon_type mon_r;
  hut_mon_type mon_nxt;

  // Run lengths of mark and of stop request; slowest bit time ever asked for, since
  // the switch point of a rate change is not visible at the pins
  always_comb begin
    mon_nxt = mon_r;
    mon_nxt.tx_run = uart_txd_o ? mon_r.tx_run + 20'h00001 : 20'h00000;
    mon_nxt.cts_run = transport_clear_to_send_in_i ? mon_r.cts_run + 20'h00001 : 20'h00000;
    if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_BAUD &&
        avs_writedata_i[15:0] > mon_r.div_hi) begin
      mon_nxt.div_hi = avs_writedata_i[15:0];
    end
  end

  // Counters do not saturate: runs longer than 2**20 cycles are out of scope
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mon_r <= '{tx_run: 20'h00000, cts_run: 20'h00000, div_hi: DIV_DEFAULT};
    end else begin
      mon_r <= mon_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_NO_REQ_NO_WAIT: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high without a request");
  AST_READ_ONE_WAIT: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read not answered after one wait cycle");
  AST_ANSWER_ONE_CYCLE: assert property (avs_read_i && !avs_waitrequest_o |=> avs_waitrequest_o || !avs_read_i)
    else $error("read answer held past one cycle");
  AST_CFG_WRITE_ONE_WAIT: assert property ($rose(avs_write_i) && avs_address_i != OFS_DATA |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("configuration write not answered in time");
  AST_LINE_IDLE_AT_START: assert property ($rose(resetn_i) |-> uart_txd_o)
    else $error("serial output not at mark after reset");
  AST_RTS_LOW_AT_START: assert property ($rose(resetn_i) |-> !uart_rts_o [*8])
    else $error("request-to-send high with an empty buffer");
  // A fall after eight or more bit times of mark is a start bit, except the even parity bit after a data byte of 0xff
  AST_NO_START_WHILE_STOPPED: assert property ($fell(uart_txd_o) &&
    mon_r.tx_run >= 20'h00008 * mon_r.div_hi |-> mon_r.cts_run <= 20'h00005)
    else $error("byte started while clear-to-send high");
  AST_ONE_BYTE_AFTER_STOP: assert property (mon_r.cts_run > 20'h0000b * mon_r.div_hi + 20'h00008 |-> uart_txd_o)
    else $error("sending went on past one byte after stop request");
endmodule : hut_uart_monitor

bind hut_uart hut_uart_monitor u_mon (.clk_i, .resetn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .uart_rxd_i, .uart_txd_o, .transport_clear_to_send_in_i, .uart_rts_o);
`default_nettype wire

// ==== test/hut_host_model.sv ====
// Behavioural host on the far side of the four-wire link.
// Assumes the bench sets the bit time and calls the tasks from one process.
`timescale 1ns/100ps
`default_nettype none
module hut_host_model
  import hut_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic [15:0] div_i, // Bit time in clock cycles
  input wire logic txd_i, // Bytes from the device
  input wire logic rts_i, // Device asks us to pause
  output logic rxd_o, // Bytes to the device
  output logic cts_o // We ask the device to pause
);
  logic [7:0] got_q[$];
  int last_low;
  int low_cnt;

  initial begin
    rxd_o = 1'b1;
    cts_o = 1'b0;
    last_low = 0;
    low_cnt = 0;
  end

  // Length of the latest low run on the device line, for bit-time checks
  always @(posedge clk_i) begin
    if (txd_i === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else begin
      if (low_cnt != 0) last_low <= low_cnt;
      low_cnt <= 0;
    end
  end

  // Receiver: mid-bit sampling, bytes with a bad stop bit are not kept
  always @(posedge clk_i) begin : rx_frame
    int w;
    logic [7:0] d;
    if (txd_i === 1'b0) begin
      w = div_i;
      repeat (w / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (w) @(posedge clk_i);
        d[i] = txd_i;
      end
      repeat (w) @(posedge clk_i);
      if (txd_i === 1'b1) got_q.push_back(d);
    end
  end

  // Start bit, then n bits LSB first; optionally wait for the device to allow sending
  task send_frame(input logic [9:0] bits, input int n, input logic heed);
    int k;
    k = 0;
    while (heed && rts_i === 1'b1 && k < 100000) begin
      @(posedge clk_i);
      k++;
    end
    rxd_o <= 1'b0;
    repeat (div_i) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= bits[i];
      repeat (div_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    @(posedge clk_i);
  endtask : send_frame

  // Any level is held for at least one bit time
  task set_cts(input logic v);
    cts_o <= v;
    repeat (div_i) @(posedge clk_i);
  endtask : set_cts
endmodule : hut_host_model
`default_nettype wire

// ==== test/test_hut_uart.sv ====
// Self-checking bench for the host-link UART transport.
// Assumes the host model answers on the serial side and the monitor is bound.
`timescale 1ns/100ps
`default_nettype none
module test_hut_uart;
  import hut_pkg::*;
  localparam logic [31:0] ONE = 32'h00000001;
  logic clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic uart_rxd_i, uart_txd_o, transport_clear_to_send_in_i, uart_rts_o;
  logic [4:0] avs_address_i;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [15:0] div;
  int failures = 0;
  int checks = 0;
  int n;

  hut_uart uut (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .uart_rxd_i, .uart_txd_o, .transport_clear_to_send_in_i, .uart_rts_o);
  hut_host_model host (.clk_i, .div_i(div), .txd_i(uart_txd_o), .rts_i(uart_rts_o),
    .rxd_o(uart_rxd_i), .cts_o(transport_clear_to_send_in_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon access: request held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 30000);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (k >= 30000) failures++;
  endtask : bus

  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    chk(what, v, exp);
  endtask : rchk

  // Wait for a byte at the host; w is the expected low run (0 skips it)
  task got(input logic [7:0] b, input logic [15:0] w);
    int k;
    k = 0;
    while (host.got_q.size() == 0 && k < 30000) begin
      @(posedge clk_i);
      k++;
    end
    chk("tx byte", {24'h000000, (k < 30000) ? host.got_q.pop_front() : ~b}, {24'h000000, b});
    if (w != 0) chk("bit time", 32'(host.last_low), {16'h0000, w});
  endtask : got

  // Hang guard, well above the expected run of about 40k cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  initial begin
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h00000000;
    div = DIV_DEFAULT;
    resetn_i = 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rchk(OFS_STATUS, 32'h00000000, "status");
    rchk(OFS_BAUD, {16'h0000, DIV_DEFAULT}, "baud");
    rchk(OFS_CTRL, 32'h00000000, "ctrl");
    rchk(5'h10, 32'h00000000, "unmapped");
    // Rate change: reply byte still at the old rate, then the new one
    wr(OFS_BAUD, 32'h0000000a);
    rchk(OFS_STATUS, ONE << ST_BAUD_PEND, "pending");
    wr(OFS_DATA, 32'h00000055);
    got(8'h55, DIV_DEFAULT);
    repeat (DIV_DEFAULT) @(posedge clk_i);
    div = DIV_MIN;
    rchk(OFS_BAUD, {16'h0000, DIV_MIN}, "new baud");
    wr(OFS_DATA, 32'h00000055);
    got(8'h55, DIV_MIN);
    // Receive, idle, underflow of an empty buffer
    host.send_frame({2'b01, 8'h3c}, 9, 1'b1);
    repeat (11 * DIV_MIN) @(posedge clk_i);
    rchk(OFS_STATUS, ONE << FL_IDLE | ONE << ST_RX_NONEMPTY | ONE << ST_COUNT_LSB, "idle");
    rchk(OFS_DATA, 32'h0000003c, "rx byte");
    rchk(OFS_DATA, 32'h00000000, "empty read");
    rchk(OFS_STATUS, ONE << FL_IDLE | ONE << FL_RX_UNDER, "rx under");
    wr(OFS_STATUS, 32'h0000007f);
    // Framing, break, parity
    host.send_frame({2'b00, 8'h5a}, 9, 1'b1);
    rchk(OFS_STATUS, ONE << FL_FRAMING, "framing");
    wr(OFS_STATUS, 32'h0000007f);
    host.send_frame({2'b00, 8'h00}, 9, 1'b1);
    rchk(OFS_STATUS, ONE << FL_BREAK | ONE << FL_FRAMING, "break");
    wr(OFS_STATUS, 32'h0000007f);
    wr(OFS_CTRL, ONE << CT_PAR_EN);
    host.send_frame({2'b10, 8'h01}, 10, 1'b1);
    rchk(OFS_STATUS, ONE << FL_PARITY | ONE << ST_RX_NONEMPTY | ONE << ST_COUNT_LSB, "parity");
    rchk(OFS_DATA, 32'h00000001, "parity byte");
    wr(OFS_STATUS, 32'h0000007f);
    wr(OFS_CTRL, ONE << CT_PAR_EN | ONE << CT_PAR_ODD);
    host.send_frame({2'b10, 8'h01}, 10, 1'b1);
    rchk(OFS_STATUS, ONE << ST_RX_NONEMPTY | ONE << ST_COUNT_LSB, "odd parity");
    rchk(OFS_DATA, 32'h00000001, "odd byte");
    wr(OFS_CTRL, 32'h00000000);
    repeat (11 * DIV_MIN) @(posedge clk_i);
    wr(OFS_STATUS, 32'h0000007f);
    // Flow control: host ignores the pause request for the allowed headroom
    for (int i = 0; i < 64; i++) begin
      host.send_frame({2'b01, 8'(i)}, 9, 1'b0);
      chk("rts", {31'h00000000, uart_rts_o}, (i >= 47) ? ONE : 32'h00000000);
    end
    rchk(OFS_STATUS, ONE << ST_RX_NONEMPTY | ONE << ST_RTS | 32'h00000040 << ST_COUNT_LSB, "full");
    host.send_frame({2'b01, 8'hee}, 9, 1'b0);
    rchk(OFS_STATUS, ONE << FL_OVERFLOW | ONE << ST_RX_NONEMPTY | ONE << ST_RTS | 32'h00000040 << ST_COUNT_LSB, "overflow");
    for (int i = 0; i < 17; i++) rchk(OFS_DATA, 32'(i), "drain");
    repeat (2) @(posedge clk_i);
    chk("rts low", {31'h00000000, uart_rts_o}, 32'h00000000);
    // Clear-to-send held high: nothing starts; released: prompt start
    host.set_cts(1'b1);
    wr(OFS_DATA, 32'h00000081);
    repeat (12 * DIV_DEFAULT) @(posedge clk_i);
    chk("held", 32'(host.got_q.size()), 32'h00000000);
    host.cts_o <= 1'b0;
    n = 0;
    while (uart_txd_o !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk("resume", 32'(n <= 200), ONE);
    got(8'h81, 16'h0000);
    // Stop request in mid-byte: that byte finishes, the next one waits
    wr(OFS_DATA, 32'h00000081);
    wr(OFS_DATA, 32'h00000042);
    n = 0;
    while (uart_txd_o !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    host.set_cts(1'b1);
    repeat (15 * DIV_MIN) @(posedge clk_i);
    chk("one byte", 32'(host.got_q.size()), ONE);
    got(8'h81, 16'h0000);
    host.set_cts(1'b0);
    got(8'h42, 16'h0000);
    // Transmit underflow in burst mode; let the previous stop bit end first
    repeat (DIV_MIN) @(posedge clk_i);
    wr(OFS_STATUS, 32'h0000007f);
    wr(OFS_CTRL, ONE << CT_TX_BURST);
    wr(OFS_DATA, 32'h00000055);
    got(8'h55, DIV_MIN);
    repeat (DIV_MIN) @(posedge clk_i);
    rchk(OFS_STATUS, ONE << FL_TX_UNDER | ONE << ST_RX_NONEMPTY | 32'h0000002f << ST_COUNT_LSB, "tx under");
    report_and_stop();
  end
endmodule : test_hut_uart
`default_nettype wire
